// file: tb_top.sv
// Purpose: self-checking bench for tcfpc_top
// Assumes: host model on the uart side, zero wait apb
// Notes: expected frames come from an integer model of the filters
`timescale 1ns/1ps
`include "tcfpc_consts.vh"
module tb_top;
   localparam int IDLE = 20;
   logic clk = 1'h0, rst = 1'h1, bo = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
   logic touch = 1'h0, sv = 1'h0, poff_n = 1'h1, slow = 1'h0, perr;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prd, seed = 32'h5F8EB77B;
   logic [9:0] sx = 10'h000, sy = 10'h000, sz = 10'h000;
   wire [31:0] prdata;
   wire [7:0] txb, rxb;
   wire pready, pslverr, txv, txr, rxv, clr, ind, osc, stby;
   logic [7:0] expq[$], lastf[$], f[$];
   int fails = 0, checks_done = 0, nclr = 0, n_os = 1, mdel = 8, fv = 4, mode = 1, pres = 1;
   int np, nf, i, j, k, t, c0, bx, by, lst[2], prv[2], st[3], dx[12], dy[12];
   initial forever #12.5 clk = ~clk;
   always @(posedge clk) if (clr) nclr <= nclr + 1;
   tcfpc_top #(.IDLE_CYC(IDLE)) uut (
      .clk_sys_i(clk), .reset_i(rst), .brownout_i(bo), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .touch_i(touch), .smp_valid_i(sv),
      .smp_x_i(sx), .smp_y_i(sy), .smp_z_i(sz), .rx_byte_i(rxb), .rx_valid_i(rxv),
      .tx_byte_o(txb), .tx_valid_o(txv), .tx_ready_i(txr), .buf_clear_o(clr),
      .power_off_n_i(poff_n), .indicator_pin_o(ind), .osc_run_o(osc), .standby_o(stby));
   tcfpc_host h (.clk_sys_i(clk), .slow_i(slow), .tx_byte_i(txb), .tx_valid_i(txv),
      .tx_ready_o(txr), .rx_byte_o(rxb), .rx_valid_o(rxv));
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function int ab(input int v);
      return v < 0 ? -v : v;
   endfunction
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask
   task results;
      if (fails == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'h1;
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (pready !== 1'h1 && t < 50);
      prd = prdata;
      perr = pslverr;
      psel <= 1'h0;
      pen <= 1'h0;
      @(posedge clk);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      chk("prdata", e, prd);
   endtask
   // one averaged point, then the filter model
   task pt(input int x, input int y);
      int s[3], v[3], a[3];
      s = '{0, 0, 0};
      repeat (n_os) begin
         for (k = 0; k < 3; k++) v[k] = (k == 2) ? rnd() % 1000 : (k ? y : x) + (rnd() & 3);
         sx <= 10'(v[0]);
         sy <= 10'(v[1]);
         sz <= 10'(v[2]);
         sv <= 1'h1;
         @(posedge clk);
         sv <= 1'h0;
         @(posedge clk);
         for (k = 0; k < 3; k++) s[k] += v[k];
      end
      for (k = 0; k < 3; k++) a[k] = s[k] / n_os;
      t = 1;
      for (k = 0; k < 2; k++) if (np >= 2 && ab(a[k] - 2 * lst[k] + prv[k]) > mdel) t = 0;
      for (k = 0; k < 2; k++) begin
         prv[k] = lst[k];
         lst[k] = a[k];
      end
      if (t) begin
         // focus runs on every axis, pressure included
         for (k = 0; k < 3; k++)
            if (np == 0 || fv == 0 || ab(a[k] - st[k]) >= fv) st[k] = a[k];
         f = {pres ? `TCFPC_HDR_Z : `TCFPC_HDR_NOZ, 8'((st[0] % 4) * 4 + st[1] % 4),
            8'(st[0] / 4), 8'(st[1] / 4)};
         if (pres) f.push_back(8'(st[2] / 8));
         if (mode == 4) lastf = f;
         else if (mode == 1 || nf == 0) expq = {expq, f};
         nf++;
      end
      np++;
      // spacing so that no report is dropped while one is sending
      repeat (40) @(posedge clk);
   endtask
   task touch_run(input int lo, input int hi);
      bx = 100 + rnd() % 300;
      by = 100 + rnd() % 300;
      np = 0;
      nf = 0;
      touch <= 1'h1;
      @(posedge clk);
      for (j = lo; j < hi; j++) pt(bx + dx[j], by + dy[j]);
      touch <= 1'h0;
      if (mode == 4) expq = {expq, lastf};
      repeat (40) @(posedge clk);
      chk("frame_len", expq.size(), h.got.size());
      for (j = 0; j < expq.size() && j < h.got.size(); j++)
         chk("frame_byte", expq[j], h.got[j]);
      expq = {};
      h.got = {};
   endtask
   initial begin
      dx = '{0, 20, 40, 100, 160, 220, 221, 0, 2, 3, 9, 10};
      dy = '{0, 0, 0, 0, 0, 40, 0, 0, 1, 5, 5, 6};
      repeat (4) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      rd(`TCFPC_OFF_CTRL, 32'h301);
      rd(`TCFPC_OFF_CFG, 32'h40808);
      rd(8'h10, 32'h0);
      chk("pslverr", 1'h1, perr);
      apb(1'h1, `TCFPC_OFF_CTRL, 32'h103);
      rd(`TCFPC_OFF_CTRL, 32'h101);
      for (i = 0; i < 6; i++) begin
         mode = 1 << (i % 3);
         pres = i % 2;
         n_os = 1 << i;
         fv = (i < 3) ? 4 : 0;
         slow <= i[0];
         apb(1'h1, `TCFPC_OFF_CTRL, 32'(pres * 256 + mode));
         apb(1'h1, `TCFPC_OFF_CFG, 32'(fv * 65536 + mdel * 256 + n_os));
         touch_run(0, 7);
      end
      mdel = 63;
      n_os = 1;
      mode = 1;
      pres = 1;
      fv = 4;
      apb(1'h1, `TCFPC_OFF_CTRL, 32'h101);
      apb(1'h1, `TCFPC_OFF_CFG, 32'h43F01);
      touch_run(7, 12);
      rd(`TCFPC_OFF_COORD, 32'(st[2] * 1048576 + st[1] * 1024 + st[0]));
      poff_n <= 1'h0;
      repeat (3) @(posedge clk);
      chk("pin_stby", 3'h5, {stby, osc, ind});
      h.send(`TCFPC_CMD_WAKE);
      touch <= 1'h1;
      repeat (3) @(posedge clk);
      chk("pin_hold", 1'h1, stby);
      rd(`TCFPC_OFF_STAT, 32'h0000000F);
      c0 = nclr;
      poff_n <= 1'h1;
      touch <= 1'h0;
      repeat (4) @(posedge clk);
      chk("pin_clear", c0 + 1, nclr);
      chk("pin_run", 1'h0, stby);
      h.send(`TCFPC_CMD_STBY);
      repeat (2) @(posedge clk);
      chk("cmd_stby", 1'h1, stby);
      touch <= 1'h1;
      repeat (4) @(posedge clk);
      chk("cmd_touch", 1'h1, stby);
      touch <= 1'h0;
      c0 = nclr;
      h.wake();
      chk("cmd_wake", 3'h2, {stby, osc, ind});
      chk("cmd_clear", c0 + 1, nclr);
      apb(1'h1, `TCFPC_OFF_CTRL, 32'h301);
      // a received byte restarts the idle count from a known edge
      h.send(8'h55);
      repeat (2) @(posedge clk);
      chk("rx_wake", 1'h0, stby);
      t = 0;
      while (stby !== 1'h1 && t < 100) begin
         @(posedge clk);
         t++;
      end
      chk("idle_span", 1'h1, t >= IDLE - 2 && t <= IDLE + 2);
      h.send(8'h55);
      repeat (2) @(posedge clk);
      chk("rx_wake2", 1'h0, stby);
      h.send(`TCFPC_CMD_STBY);
      repeat (2) @(posedge clk);
      chk("cmd_stby2", 1'h1, stby);
      touch <= 1'h1;
      repeat (3) @(posedge clk);
      chk("touch_wake", 1'h0, stby);
      touch <= 1'h0;
      h.send(`TCFPC_CMD_SPD);
      rd(`TCFPC_OFF_CTRL, 32'h101);
      bo <= 1'h1;
      repeat (20) @(posedge clk);
      bo <= 1'h0;
      @(posedge clk);
      rd(`TCFPC_OFF_CTRL, 32'h301);
      results();
   end
   initial begin
      repeat (90000) @(posedge clk);
      fails++;
      results();
   end
endmodule

// file: tcfpc_consts.vh
// Purpose: constants for the touch coordinate filter and power block
// Assumes: 40 MHz system clock
// Notes: register byte offsets on the APB word map
`ifndef TCFPC_CONSTS_VH
`define TCFPC_CONSTS_VH
`define TCFPC_OFF_CTRL 8'h00
`define TCFPC_OFF_CFG 8'h04
`define TCFPC_OFF_STAT 8'h08
`define TCFPC_OFF_COORD 8'h0C
`define TCFPC_MODE_STREAM 8'h01
`define TCFPC_MODE_TDOWN 8'h02
`define TCFPC_MODE_LIFT 8'h04
`define TCFPC_OS_DEF 8'h08
`define TCFPC_DELTA_DEF 6'h08
`define TCFPC_FOCUS_DEF 6'h04
`define TCFPC_CMD_SPD 8'hA2
`define TCFPC_CMD_WAKE 8'hA7
`define TCFPC_CMD_STBY 8'hA8
`define TCFPC_HDR_NOZ 8'h80
`define TCFPC_HDR_Z 8'h90
`define TCFPC_IDLE_US 1000
`define TCFPC_CLK_MHZ 40
`endif

// file: tcfpc_host.sv
// Purpose: host driver model on the uart side of tcfpc_top
// Assumes: byte level uart, one strobe per byte
// Notes: slow_i stalls the sink three cycles in four
`timescale 1ns/1ps
`include "tcfpc_consts.vh"
module tcfpc_host #(
   parameter WAKE_CYC = 40000
) (
   // clock and stall control
   input wire clk_sys_i,
   input wire slow_i,
   // byte sink
   input wire [7:0] tx_byte_i,
   input wire tx_valid_i,
   output logic tx_ready_o,
   // byte source
   output logic [7:0] rx_byte_o,
   output logic rx_valid_o
);
   logic [7:0] got[$];
   logic [1:0] cnt_q = 2'h0;
   initial begin
      tx_ready_o = 1'h0;
      rx_byte_o = 8'h00;
      rx_valid_o = 1'h0;
   end
   always @(posedge clk_sys_i) begin
      cnt_q <= cnt_q + 2'h1;
      tx_ready_o <= !slow_i || cnt_q == 2'h3;
      if (tx_valid_i && tx_ready_o) got.push_back(tx_byte_i);
   end
   task send(input logic [7:0] b);
      @(posedge clk_sys_i);
      rx_byte_o <= b;
      rx_valid_o <= 1'h1;
      @(posedge clk_sys_i);
      rx_valid_o <= 1'h0;
      // released line must not keep showing the byte
      rx_byte_o <= ~b;
   endtask
   task wake;
      send(`TCFPC_CMD_WAKE);
      // oscillator restart time before any command
      repeat (WAKE_CYC) @(posedge clk_sys_i);
   endtask
endmodule

// file: tcfpc_properties.sv
// Purpose: port assertions for tcfpc_top
// Assumes: sync resets, state flop updates at the taking edge or the next
// Notes: attached by the bind below
`timescale 1ns/1ps
`include "tcfpc_consts.vh"
module tcfpc_properties #(
   parameter IDLE_CYC = 20
) (
   // clock and resets
   input wire clk_sys_i,
   input wire reset_i,
   input wire brownout_i,
   // uart side
   input wire [7:0] rx_byte_i,
   input wire rx_valid_i,
   input wire [7:0] tx_byte_o,
   input wire tx_valid_o,
   input wire tx_ready_i,
   input wire buf_clear_o,
   // power
   input wire power_off_n_i,
   input wire indicator_pin_o,
   input wire osc_run_o,
   input wire standby_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (reset_i || brownout_i);
   a_stby_pins: assert property (standby_o |-> indicator_pin_o && !osc_run_o)
      else $error("standby outputs wrong");
   a_stby_quiet: assert property (standby_o && $past(standby_o) |-> !tx_valid_o)
      else $error("report sent in standby");
   a_pin_stby: assert property (!power_off_n_i ##1 !power_off_n_i |-> standby_o)
      else $error("pin low without standby");
   a_pin_mute: assert property (!power_off_n_i ##1 !power_off_n_i |-> !buf_clear_o)
      else $error("clear while pin low");
   a_pin_clear: assert property ($rose(power_off_n_i) |-> ##[1:3] buf_clear_o)
      else $error("no clear after pin release");
   a_cmd_stby: assert property (rx_valid_i && power_off_n_i && !standby_o
      && rx_byte_i == `TCFPC_CMD_STBY |-> ##[1:2] standby_o)
      else $error("standby command not taken");
   a_cmd_wake: assert property (rx_valid_i && power_off_n_i && standby_o
      && rx_byte_i == `TCFPC_CMD_WAKE |-> ##[1:2] !standby_o)
      else $error("wakeup command not taken");
   a_clr_pulse: assert property (buf_clear_o |=> !buf_clear_o)
      else $error("clear longer than one cycle");
   a_frame_hdr: assert property ($rose(tx_valid_o) |->
      tx_byte_o == `TCFPC_HDR_Z || tx_byte_o == `TCFPC_HDR_NOZ)
      else $error("bad frame header");
   a_byte_hold: assert property (tx_valid_o && !tx_ready_i && !standby_o && !buf_clear_o
      |=> tx_valid_o && $stable(tx_byte_o))
      else $error("byte dropped before accept");
   a_brown_init: assert property (disable iff (reset_i) brownout_i |=>
      !standby_o && !tx_valid_o && !buf_clear_o)
      else $error("brownout did not initialise");
   c_cmd_stby: cover property (rx_valid_i && rx_byte_i == `TCFPC_CMD_STBY ##[1:2] standby_o);
   c_pin_wake: cover property ($rose(power_off_n_i) ##[1:3] buf_clear_o);
   c_frame: cover property ($rose(tx_valid_o) ##[1:40] $fell(tx_valid_o));
endmodule
bind tcfpc_top tcfpc_properties #(.IDLE_CYC(IDLE_CYC)) u_props (
   .clk_sys_i(clk_sys_i), .reset_i(reset_i), .brownout_i(brownout_i),
   .rx_byte_i(rx_byte_i), .rx_valid_i(rx_valid_i), .tx_byte_o(tx_byte_o),
   .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .buf_clear_o(buf_clear_o),
   .power_off_n_i(power_off_n_i), .indicator_pin_o(indicator_pin_o),
   .osc_run_o(osc_run_o), .standby_o(standby_o));

// file: tcfpc_top.v
// Purpose: oversample, delta and focus filter touch coordinates, frame
//    reports, and manage standby entry and wake
// Assumes: sample inputs synchronous to clk_sys_i; byte sink has ready
// Notes: report bytes leave on a byte stream to the UART transmitter
//
// Overview of operation
// - pressure on: fifth byte carries Z 0-127
// - standby via toggle, power-off pin, command
// - self power down: idle sleeps, activity wakes
// - standby stops activity, indicator pin high
// - power-off pin low ignores touch and UART
// - pin release clears UART buffers, resumes
// - command standby wakes by wakeup, touch if enabled
// - command standby wake clears UART buffers
// - oversample 1..32 per axis, default 8
// - predict last plus last difference
// - close samples pass, others only kept history
// - max delta 0-63, default 8
// - focus sends new if far, else stored
// - focus 0-63, zero disables, default 4
// - liftoff mode sends final coordinate only
// - touchdown mode sends first coordinate only
// - streaming mode sends while touched
// - reset input or brownout initialises all
// - mode codes 01 stream, 02 down, 04 lift
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
`include "tcfpc_consts.vh"
module tcfpc_top #(
   parameter IDLE_CYC = `TCFPC_IDLE_US * `TCFPC_CLK_MHZ
) (
   // clock and resets
   input wire clk_sys_i,
   input wire reset_i,
   input wire brownout_i,
   // apb slave
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   output wire [31:0] prdata_o,
   output wire pready_o,
   output wire pslverr_o,
   // touch samples
   input wire touch_i,
   input wire smp_valid_i,
   input wire [9:0] smp_x_i,
   input wire [9:0] smp_y_i,
   input wire [9:0] smp_z_i,
   // uart side
   input wire [7:0] rx_byte_i,
   input wire rx_valid_i,
   output wire [7:0] tx_byte_o,
   output wire tx_valid_o,
   input wire tx_ready_i,
   output wire buf_clear_o,
   // power
   input wire power_off_n_i,
   output wire indicator_pin_o,
   output wire osc_run_o,
   output wire standby_o
);
   localparam ST_RUN = 2'b00;
   localparam ST_AUTO = 2'b01;
   localparam ST_CMD = 2'b10;
   localparam ST_PIN = 2'b11;
   localparam TX_IDLE = 1'b0;
   localparam TX_SEND = 1'b1;

   function [11:0] absd;
      input [11:0] a;
      input [11:0] b;
      reg [11:0] d;
      begin
         d = a - b;
         absd = d[11] ? (~d + 12'h001) : d;
      end
   endfunction

   function [2:0] os_shift;
      input [7:0] code;
      begin
         case (code)
            8'h01: os_shift = 3'h0;
            8'h02: os_shift = 3'h1;
            8'h04: os_shift = 3'h2;
            8'h08: os_shift = 3'h3;
            8'h10: os_shift = 3'h4;
            8'h20: os_shift = 3'h5;
            default: os_shift = 3'h7;
         endcase
      end
   endfunction

   // sum can reach 15 bits; the shifted mean always fits ten
   function [9:0] avg_of;
      input [14:0] acc;
      input [9:0] smp;
      input [2:0] shift;
      reg [14:0] s;
      begin
         s = (acc + {5'h00, smp}) >> shift;
         avg_of = s[9:0];
      end
   endfunction

   wire rst = reset_i | brownout_i;
   integer i;
   integer i_os, i_fl, i_rp, i_tx;

   // configuration
   reg [7:0] mode_q;
   reg pres_en_q;
   reg spd_en_q;
   reg [7:0] os_q;
   reg [5:0] maxd_q;
   reg [5:0] foc_q;
   // apb answer
   reg [31:0] prdata_q;
   reg pready_q;
   reg pslverr_q;
   // power
   reg [1:0] pst_q;
   reg [31:0] idle_q;
   reg clr_q;
   reg stby_q;
   reg osc_q;
   // oversampling
   reg [14:0] acc_q [0:2];
   reg [5:0] cnt_q;
   reg [9:0] avg_q [0:2];
   reg avg_v_q;
   // filters
   reg [9:0] h1_q [0:2];
   reg [9:0] h2_q [0:2];
   reg [1:0] hn_q;
   reg [9:0] fp_q [0:2];
   reg fp_v_q;
   reg [9:0] rep_q [0:2];
   reg rep_v_q;
   // reporting
   reg touch_q;
   reg sent_q;
   reg [9:0] hold_q [0:2];
   reg hold_v_q;
   reg [9:0] last_q [0:2];
   // transmit
   reg tx_st_q;
   reg [2:0] tx_idx_q;
   reg [7:0] tx_byte_q;
   reg tx_valid_q;
   reg [7:0] tb_q [0:4];
   reg [2:0] tx_n_q;

   wire stby = (pst_q != ST_RUN);
   wire setup = psel_i & ~penable_i;
   wire wr = psel_i & penable_i & pwrite_i;
   wire rx_ok = rx_valid_i & power_off_n_i;
   wire [2:0] sh = os_shift(os_q);
   wire [5:0] os_last = os_q[5:0] - 6'h01;

   // filter combinational view, one lane per axis
   reg [11:0] pred [0:2];
   reg [2:0] dok;
   reg [9:0] fo [0:2];
   reg [2:0] fnew;
   always @* begin
      for (i = 0; i < 3; i = i + 1) begin
         pred[i] = {1'b0, h1_q[i], 1'b0} - {2'b00, h2_q[i]};
         dok[i] = (hn_q != 2'b10) ||
            (absd({2'b00, avg_q[i]}, pred[i]) <= {6'h00, maxd_q});
         fnew[i] = (foc_q == 6'h00) || !fp_v_q ||
            (absd({2'b00, avg_q[i]}, {2'b00, fp_q[i]}) >= {6'h00, foc_q});
         fo[i] = fnew[i] ? avg_q[i] : fp_q[i];
      end
   end

   // register file and apb
   always @(posedge clk_sys_i) begin
      if (rst) begin
         mode_q <= `TCFPC_MODE_STREAM;
         pres_en_q <= 1'b1;
         spd_en_q <= 1'b1;
         os_q <= `TCFPC_OS_DEF;
         maxd_q <= `TCFPC_DELTA_DEF;
         foc_q <= `TCFPC_FOCUS_DEF;
         prdata_q <= 32'h00000000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= 1'b1;
         if (setup) begin
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
            case (paddr_i)
               `TCFPC_OFF_CTRL: prdata_q <= {22'h0, spd_en_q, pres_en_q, mode_q};
               `TCFPC_OFF_CFG: prdata_q <= {10'h0, foc_q, 2'b00, maxd_q, os_q};
               `TCFPC_OFF_STAT:
                  prdata_q <= {27'h0, hold_v_q, touch_i, ~power_off_n_i, pst_q};
               `TCFPC_OFF_COORD:
                  prdata_q <= {2'b00, last_q[2], last_q[1], last_q[0]};
               default: pslverr_q <= 1'b1;
            endcase
         end
         if (wr && paddr_i == `TCFPC_OFF_CTRL) begin
            // unknown mode codes keep the old mode
            if (pwdata_i[7:0] == `TCFPC_MODE_STREAM ||
                pwdata_i[7:0] == `TCFPC_MODE_TDOWN ||
                pwdata_i[7:0] == `TCFPC_MODE_LIFT) begin
               mode_q <= pwdata_i[7:0];
            end
            pres_en_q <= pwdata_i[8];
            spd_en_q <= pwdata_i[9];
         end else if (rx_ok && pst_q == ST_RUN && rx_byte_i == `TCFPC_CMD_SPD) begin
            spd_en_q <= ~spd_en_q;
         end
         if (wr && paddr_i == `TCFPC_OFF_CFG) begin
            if (os_shift(pwdata_i[7:0]) != 3'h7) begin
               os_q <= pwdata_i[7:0];
            end
            maxd_q <= pwdata_i[13:8];
            foc_q <= pwdata_i[21:16];
         end
      end
   end

   // power state
   always @(posedge clk_sys_i) begin
      if (rst) begin
         pst_q <= ST_RUN;
         idle_q <= 32'h00000000;
         clr_q <= 1'b0;
         stby_q <= 1'b0;
         osc_q <= 1'b1;
      end else begin
         clr_q <= 1'b0;
         if (touch_i || rx_ok) begin
            idle_q <= 32'h00000000;
         end else if (idle_q < IDLE_CYC) begin
            idle_q <= idle_q + 32'h00000001;
         end
         case (pst_q)
            ST_RUN: begin
               if (!power_off_n_i) begin
                  pst_q <= ST_PIN;
                  {stby_q, osc_q} <= 2'b10;
               end else if (rx_ok && rx_byte_i == `TCFPC_CMD_STBY) begin
                  pst_q <= ST_CMD;
                  {stby_q, osc_q} <= 2'b10;
               end else if (spd_en_q && idle_q >= IDLE_CYC) begin
                  pst_q <= ST_AUTO;
                  {stby_q, osc_q} <= 2'b10;
               end
            end
            ST_AUTO: begin
               if (!power_off_n_i) begin
                  pst_q <= ST_PIN;
               end else if (touch_i || rx_ok) begin
                  pst_q <= ST_RUN;
                  {stby_q, osc_q} <= 2'b01;
                  idle_q <= 32'h00000000;
               end
            end
            ST_CMD: begin
               if (!power_off_n_i) begin
                  pst_q <= ST_PIN;
               end else if ((rx_ok && rx_byte_i == `TCFPC_CMD_WAKE) ||
                            (spd_en_q && touch_i)) begin
                  pst_q <= ST_RUN;
                  {stby_q, osc_q} <= 2'b01;
                  clr_q <= 1'b1;
                  idle_q <= 32'h00000000;
               end
            end
            ST_PIN: begin
               if (power_off_n_i) begin
                  pst_q <= ST_RUN;
                  {stby_q, osc_q} <= 2'b01;
                  clr_q <= 1'b1;
                  idle_q <= 32'h00000000;
               end
            end
            default: begin
               pst_q <= ST_RUN;
               {stby_q, osc_q} <= 2'b01;
            end
         endcase
      end
   end

   // oversampling, stopped in standby
   always @(posedge clk_sys_i) begin
      if (rst) begin
         for (i_os = 0; i_os < 3; i_os = i_os + 1) begin
            acc_q[i_os] <= 15'h0000;
            avg_q[i_os] <= 10'h000;
         end
         cnt_q <= 6'h00;
         avg_v_q <= 1'b0;
      end else begin
         avg_v_q <= 1'b0;
         if (stby || !touch_i) begin
            cnt_q <= 6'h00;
            for (i_os = 0; i_os < 3; i_os = i_os + 1) acc_q[i_os] <= 15'h0000;
         end else if (smp_valid_i) begin
            if (cnt_q == os_last) begin
               cnt_q <= 6'h00;
               avg_v_q <= 1'b1;
               for (i_os = 0; i_os < 3; i_os = i_os + 1) acc_q[i_os] <= 15'h0000;
               avg_q[0] <= avg_of(acc_q[0], smp_x_i, sh);
               avg_q[1] <= avg_of(acc_q[1], smp_y_i, sh);
               avg_q[2] <= avg_of(acc_q[2], smp_z_i, sh);
            end else begin
               cnt_q <= cnt_q + 6'h01;
               acc_q[0] <= acc_q[0] + {5'h00, smp_x_i};
               acc_q[1] <= acc_q[1] + {5'h00, smp_y_i};
               acc_q[2] <= acc_q[2] + {5'h00, smp_z_i};
            end
         end
      end
   end

   // delta and focus filters; history restarts with each touch
   always @(posedge clk_sys_i) begin
      if (rst) begin
         for (i_fl = 0; i_fl < 3; i_fl = i_fl + 1) begin
            h1_q[i_fl] <= 10'h000;
            h2_q[i_fl] <= 10'h000;
            fp_q[i_fl] <= 10'h000;
            rep_q[i_fl] <= 10'h000;
         end
         hn_q <= 2'b00;
         fp_v_q <= 1'b0;
         rep_v_q <= 1'b0;
      end else begin
         rep_v_q <= 1'b0;
         if (!touch_i) begin
            hn_q <= 2'b00;
            fp_v_q <= 1'b0;
         end else if (avg_v_q) begin
            for (i_fl = 0; i_fl < 3; i_fl = i_fl + 1) begin
               h2_q[i_fl] <= h1_q[i_fl];
               h1_q[i_fl] <= avg_q[i_fl];
               rep_q[i_fl] <= fo[i_fl];
               if (dok[1:0] == 2'b11 && fnew[i_fl]) fp_q[i_fl] <= avg_q[i_fl];
            end
            if (hn_q != 2'b10) hn_q <= hn_q + 2'b01;
            // a pair is reported only when both planar axes pass
            if (dok[1:0] == 2'b11) begin
               rep_v_q <= 1'b1;
               fp_v_q <= 1'b1;
            end
         end
      end
   end

   // reporting modes and byte framing
   wire fall = touch_q & ~touch_i;
   wire go_str = rep_v_q && mode_q == `TCFPC_MODE_STREAM;
   wire go_td = rep_v_q && mode_q == `TCFPC_MODE_TDOWN && !sent_q;
   // a report landing on the release edge is the final one and wins
   wire go_lo = fall && (hold_v_q || rep_v_q) && mode_q == `TCFPC_MODE_LIFT;
   wire go = (go_str | go_td | go_lo) && tx_st_q == TX_IDLE && !stby;
   wire use_hold = go_lo && !rep_v_q;
   wire [9:0] sx = use_hold ? hold_q[0] : rep_q[0];
   wire [9:0] sy = use_hold ? hold_q[1] : rep_q[1];
   wire [9:0] sz = use_hold ? hold_q[2] : rep_q[2];

   always @(posedge clk_sys_i) begin
      if (rst) begin
         touch_q <= 1'b0;
         sent_q <= 1'b0;
         hold_v_q <= 1'b0;
         for (i_rp = 0; i_rp < 3; i_rp = i_rp + 1) begin
            hold_q[i_rp] <= 10'h000;
            last_q[i_rp] <= 10'h000;
         end
      end else begin
         touch_q <= touch_i;
         if (!touch_i) begin
            sent_q <= 1'b0;
         end else if (go_td) begin
            sent_q <= 1'b1;
         end
         if (fall) begin
            hold_v_q <= 1'b0;
         end else if (rep_v_q) begin
            hold_v_q <= 1'b1;
            for (i_rp = 0; i_rp < 3; i_rp = i_rp + 1) hold_q[i_rp] <= rep_q[i_rp];
         end
         if (go) begin
            last_q[0] <= sx;
            last_q[1] <= sy;
            last_q[2] <= sz;
         end
      end
   end

   // transmit sequencer; a report arriving while busy is dropped
   always @(posedge clk_sys_i) begin
      if (rst || clr_q) begin
         tx_st_q <= TX_IDLE;
         tx_idx_q <= 3'h0;
         tx_byte_q <= 8'h00;
         tx_valid_q <= 1'b0;
         tx_n_q <= 3'h4;
         for (i_tx = 0; i_tx < 5; i_tx = i_tx + 1) tb_q[i_tx] <= 8'h00;
      end else begin
         case (tx_st_q)
            TX_IDLE: begin
               if (go) begin
                  tx_st_q <= TX_SEND;
                  tx_idx_q <= 3'h0;
                  tx_valid_q <= 1'b1;
                  tx_byte_q <= pres_en_q ? `TCFPC_HDR_Z : `TCFPC_HDR_NOZ;
                  tb_q[1] <= {4'h0, sx[1:0], sy[1:0]};
                  tb_q[2] <= sx[9:2];
                  tb_q[3] <= sy[9:2];
                  tb_q[4] <= {1'b0, sz[9:3]};
                  tx_n_q <= pres_en_q ? 3'h5 : 3'h4;
               end
            end
            TX_SEND: begin
               if (stby) begin
                  tx_valid_q <= 1'b0;
                  tx_st_q <= TX_IDLE;
               end else if (tx_ready_i) begin
                  if (tx_idx_q + 3'h1 == tx_n_q) begin
                     tx_valid_q <= 1'b0;
                     tx_st_q <= TX_IDLE;
                  end else begin
                     tx_idx_q <= tx_idx_q + 3'h1;
                     tx_byte_q <= tb_q[tx_idx_q + 3'h1];
                  end
               end
            end
            default: tx_st_q <= TX_IDLE;
         endcase
      end
   end

   assign prdata_o = prdata_q;
   assign pready_o = pready_q;
   assign pslverr_o = pslverr_q;
   assign tx_byte_o = tx_byte_q;
   assign tx_valid_o = tx_valid_q;
   assign buf_clear_o = clr_q;
   assign standby_o = stby_q;
   assign indicator_pin_o = stby_q;
   assign osc_run_o = osc_q;
endmodule
